// ### sarro_cfg.svh
/*
 constants for the serial readout of the converter: frame layout and timing.
 assumes inclusion by the package and by every design file that needs them.
*/
`ifndef SARRO_CFG_SVH
`define SARRO_CFG_SVH
`define SARRO_RES_BITS      12
`define SARRO_FRAME_BITS    16
`define SARRO_LEAD_ZEROS    4
`define SARRO_CNT_W         5
`define SARRO_TRACK_RISE    5'h0D
`define SARRO_LAST_FALL     5'h10
`define SARRO_FIFO_DEPTH    8
`define SARRO_CORE_MHZ      250
`define SARRO_PWRUP_NS      1400
`define SARRO_PWRUP_CYC     ((`SARRO_PWRUP_NS * `SARRO_CORE_MHZ + 999) / 1000)
`endif

// ### sarro_fifo.sv
/*
 small synchronous fifo of flip-flops with valid and ready on both sides.
 assumes one clock and active-low asynchronous reset; depth is a power of two.
*/
`timescale 1ns/1ps
`default_nettype none
module sarro_fifo
  #(
    parameter int WIDTH = 13,
    parameter int DEPTH = 8
  )
  (
    // clock and reset
    input  wire logic             core_clk,
    input  wire logic             reset_n,
    // fill side
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // drain side
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
  );
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      count;
  logic             push;
  logic             pop;

  assign in_ready  = (count != (AW+1)'(DEPTH));
  assign out_valid = (count != '0);
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign out_data  = mem[rd_ptr];

  always_ff @(posedge core_clk)
  begin
    if (push)
    begin
      mem[wr_ptr] <= in_data;
    end
  end

  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end
    else
    begin
      if (push)
      begin
        wr_ptr <= wr_ptr + AW'(1);
      end
      if (pop)
      begin
        rd_ptr <= rd_ptr + AW'(1);
      end
      if (push && !pop)
      begin
        count <= count + (AW+1)'(1);
      end
      else if (pop && !push)
      begin
        count <= count - (AW+1)'(1);
      end
    end
  end
endmodule // sarro_fifo
`default_nettype wire

// ### sarro_host.sv
/*
 host serial port model: select, serial clock, bit capture.
 assumes the caller spaces frames; the clock stands high outside frames.
*/
`timescale 1ns/1ps
`default_nettype none
module sarro_host
  (
    // link pins
    output logic     shift_conv_clock,
    output logic     conv_select_n,
    input wire logic serial_result_out,
    input wire logic serial_result_oe_n
  );
  localparam realtime HALF = 7.5;
  logic bus_line;
  // a released line reads as the inverse of serial_result_out
  assign bus_line = serial_result_oe_n ? ~serial_result_out : serial_result_out;
  initial
  begin
    shift_conv_clock = 1'b1;
    conv_select_n    = 1'b1;
  end
  // one frame of n clocks; fewer than 16 ends in an abort
  task automatic frame(input int n, output logic [15:0] word);
    word = '0;
    #3.3;
    conv_select_n = 1'b0;
    #1420; // minimum plus margin for the acquisition flag
    conv_select_n = 1'b1;
    #HALF;
    word[15] = bus_line;
    for (int k = 1; k <= n; k++)
    begin
      shift_conv_clock = 1'b0;
      #HALF;
      shift_conv_clock = 1'b1;
      if (k < 16)
        word[15-k] = bus_line;
      #HALF;
    end
    if (n < 16)
      conv_select_n = 1'b0;
  endtask
endmodule // sarro_host
`default_nettype wire

// ### sarro_pkg.sv
/*
 types shared by the readout block and its testbench.
 assumes sarro_cfg.svh is on the include path.
*/
`include "sarro_cfg.svh"
package sarro_pkg;
  typedef logic [`SARRO_RES_BITS-1:0] sarro_code_type;
  typedef struct packed
  {
    logic           aborted;
    sarro_code_type code;
  } sarro_sample_type;
  typedef enum logic [1:0]
  {
    SARRO_SLEEP = 2'b00,
    SARRO_TRACK = 2'b01,
    SARRO_CONV  = 2'b10
  } sarro_state_type;
endpackage

// ### sarro_readout.sv
/*
 conversion control and serial readout of a 12-bit successive-approximation converter.
 link side runs on shift_conv_clock; core side on core_clk. conv_select_n is asynchronous.
 converted codes arrive from the analog core through a fifo on core_clk.
*/
// Function
// - a falling select wakes the device and puts the track and hold into tracking.
// - a rising select starts a conversion, holds the input and enables the data driver.
// - a conversion takes 16 cycles of the serial clock.
// - after the 16th falling serial edge the driver floats and the device sleeps until select falls.
// - select falling before 16 bits are out aborts, floats the driver and returns to tracking.
// - after an abort the next rising select starts a normal conversion ending in sleep.
// - each frame is four zeros then the 12-bit result, most significant bit first.
// - the result is straight unsigned binary.
// - the data output changes only on falling serial edges.
// - the rising select presents the first leading zero.
// - the first falling serial edge presents the second zero and each later one the next bit.
// - the last result bit is driven on the 15th falling edge and is valid at the 16th.
// - the track and hold returns to tracking on the 13th rising serial edge.
`timescale 1ns/1ps
`default_nettype none
module sarro_readout
  import sarro_pkg::*;
  #(
    parameter int FIFO_DEPTH = `SARRO_FIFO_DEPTH
  )
  (
    // core clock and reset
    input  wire logic           core_clk,
    input  wire logic           reset_n,
    // link pins
    input  wire logic           shift_conv_clock,
    input  wire logic           conv_select_n,
    output logic                serial_result_out,
    output logic                serial_result_oe_n,
    // analog core control
    output logic                track_hold,
    output logic                powered_up,
    output logic                acq_done,
    // result from the analog core
    input  wire logic           code_valid,
    output logic                code_ready,
    input  wire sarro_code_type code_in,
    // finished frames, reported on core_clk
    output logic                frame_done,
    output logic                frame_aborted
  );

  // ---------------- link domain ----------------
  // the select pin and the core reset both clear the frame logic; the select rise starts it
  logic [`SARRO_CNT_W-1:0] fall_cnt;
  logic [`SARRO_CNT_W-1:0] rise_cnt;
  logic [`SARRO_FRAME_BITS-1:0] shreg;
  logic                    frame_end;
  logic                    done_tog;
  logic                    abort_tog;
  logic                    hold_rise;
  logic                    link_clr;
  logic                    link_live;
  logic                    started;
  logic                    conv_active;
  sarro_code_type          held_code;
  sarro_code_type          head_code;

  // select low or core reset clears the frame logic
  assign link_clr = !conv_select_n || !reset_n;

  function automatic logic [`SARRO_FRAME_BITS-1:0] build_frame(input sarro_code_type c);
    build_frame = {{`SARRO_LEAD_ZEROS{1'b0}}, c};
  endfunction

  function automatic logic [`SARRO_FRAME_BITS-1:0] shift_up
    (input logic [`SARRO_FRAME_BITS-1:0] v);
    shift_up = {v[`SARRO_FRAME_BITS-2:0], 1'b0};
  endfunction

  // rising select takes the head code, which stands still until the frame completes
  always_ff @(posedge conv_select_n or negedge reset_n)
  begin
    if (!reset_n)
    begin
      held_code <= '0;
    end
    else
    begin
      held_code <= head_code;
    end
  end

  // frame shift counters on falling and rising serial edges, cleared while select is low
  always_ff @(negedge shift_conv_clock or posedge link_clr)
  begin
    if (link_clr)
    begin
      fall_cnt <= '0;
    end
    else if (fall_cnt != `SARRO_LAST_FALL)
    begin
      fall_cnt <= fall_cnt + `SARRO_CNT_W'(1);
    end
  end

  always_ff @(posedge shift_conv_clock or posedge link_clr)
  begin
    if (link_clr)
    begin
      rise_cnt <= '0;
    end
    else if (rise_cnt != `SARRO_LAST_FALL)
    begin
      rise_cnt <= rise_cnt + `SARRO_CNT_W'(1);
    end
  end

  // track and hold returns to tracking on the 13th rising edge
  always_ff @(posedge shift_conv_clock or posedge link_clr)
  begin
    if (link_clr)
    begin
      hold_rise <= 1'b0;
    end
    else if (rise_cnt == `SARRO_TRACK_RISE - `SARRO_CNT_W'(1))
    begin
      hold_rise <= 1'b1;
    end
  end

  // shift register: the cleared zero stands from the select rise, the first fall loads
  // the frame already advanced by one bit, later falls shift
  always_ff @(negedge shift_conv_clock or posedge link_clr)
  begin
    if (link_clr)
    begin
      shreg <= '0;
    end
    else if (fall_cnt == '0)
    begin
      shreg <= shift_up(build_frame(held_code));
    end
    else
    begin
      shreg <= shift_up(shreg);
    end
  end

  assign frame_end   = (fall_cnt == `SARRO_LAST_FALL);
  assign link_live   = conv_select_n && started;
  assign conv_active = link_live && !frame_end;

  always_comb
  begin
    serial_result_out  = shreg[`SARRO_FRAME_BITS-1];
    serial_result_oe_n = !conv_active;
    track_hold         = !link_live || hold_rise || frame_end;
  end

  // completion toggle on the 16th fall
  always_ff @(negedge shift_conv_clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      done_tog <= 1'b0;
    end
    else if (conv_select_n && fall_cnt == `SARRO_LAST_FALL - `SARRO_CNT_W'(1))
    begin
      done_tog <= ~done_tog;
    end
  end

  // abort toggle: select falls while a frame is unfinished
  always_ff @(negedge conv_select_n or negedge reset_n)
  begin
    if (!reset_n)
    begin
      abort_tog <= 1'b0;
    end
    else if (!frame_end && started)
    begin
      abort_tog <= ~abort_tog;
    end
  end

  // set by the first select rise after reset, so an idle link stays quiet
  always_ff @(posedge conv_select_n or negedge reset_n)
  begin
    if (!reset_n)
    begin
      started <= 1'b0;
    end
    else
    begin
      started <= 1'b1;
    end
  end

  // ---------------- core domain ----------------
  sarro_state_type state;
  sarro_state_type next_state;
  logic [1:0]      sel_sync;
  logic [2:0]      done_sync;
  logic [2:0]      abort_sync;
  logic [$clog2(`SARRO_PWRUP_CYC+1)-1:0] acq_cnt;
  sarro_code_type  fifo_code;
  logic            fifo_valid;
  logic            take;

  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      sel_sync   <= 2'h3;
      done_sync  <= '0;
      abort_sync <= '0;
    end
    else
    begin
      sel_sync   <= {sel_sync[0], conv_select_n};
      done_sync  <= {done_sync[1:0], done_tog};
      abort_sync <= {abort_sync[1:0], abort_tog};
    end
  end

  logic sel_low;
  logic done_evt;
  logic abort_evt;
  assign sel_low   = !sel_sync[1];
  assign done_evt  = done_sync[2] ^ done_sync[1];
  assign abort_evt = abort_sync[2] ^ abort_sync[1];

  always_comb
  begin
    next_state = state;
    case (state)
      SARRO_SLEEP:
      begin
        if (sel_low)
        begin
          next_state = SARRO_TRACK;
        end
      end
      SARRO_TRACK:
      begin
        if (!sel_low)
        begin
          next_state = SARRO_CONV;
        end
      end
      SARRO_CONV:
      begin
        if (done_evt)
        begin
          next_state = SARRO_SLEEP;
        end
        else if (sel_low)
        begin
          next_state = SARRO_TRACK;
        end
      end
      default:
      begin
        next_state = SARRO_SLEEP;
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state <= SARRO_SLEEP;
    end
    else
    begin
      state <= next_state;
    end
  end

  // power-up and acquisition timer, informative only; the host guarantees the time
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      acq_cnt <= '0;
    end
    else if (state != SARRO_TRACK)
    begin
      acq_cnt <= '0;
    end
    else if (acq_cnt != ($bits(acq_cnt))'(`SARRO_PWRUP_CYC))
    begin
      acq_cnt <= acq_cnt + ($bits(acq_cnt))'(1);
    end
  end

  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      powered_up    <= 1'b0;
      acq_done      <= 1'b0;
      frame_done    <= 1'b0;
      frame_aborted <= 1'b0;
    end
    else
    begin
      powered_up    <= (next_state != SARRO_SLEEP);
      acq_done      <= (acq_cnt == ($bits(acq_cnt))'(`SARRO_PWRUP_CYC));
      frame_done    <= done_evt;
      frame_aborted <= abort_evt;
    end
  end

  // head word kept in a register: the select domain samples a settled value, and an
  // empty fifo leaves the last word in place
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      head_code <= '0;
    end
    else if (fifo_valid)
    begin
      head_code <= fifo_code;
    end
  end

  // code fifo: drained one word per completed frame, stalling the analog core when full
  assign take = done_evt && fifo_valid;

  sarro_fifo
    #(
      .WIDTH ($bits(sarro_code_type)),
      .DEPTH (FIFO_DEPTH)
    )
    u_fifo
    (
      .core_clk  (core_clk),
      .reset_n   (reset_n),
      .in_valid  (code_valid),
      .in_ready  (code_ready),
      .in_data   (code_in),
      .out_valid (fifo_valid),
      .out_ready (take),
      .out_data  (fifo_code)
    );
endmodule // sarro_readout
`default_nettype wire

// ### sarro_readout_props.sv
/*
 port checker for the converter readout block.
 assumes the host idles the serial clock high between frames.
*/
`timescale 1ns/1ps
`default_nettype none
module sarro_readout_props
  (
    // clocks and reset
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic shift_conv_clock,
    // link pins
    input wire logic conv_select_n,
    input wire logic serial_result_out,
    input wire logic serial_result_oe_n,
    // core side
    input wire logic track_hold,
    input wire logic powered_up,
    input wire logic frame_done,
    input wire logic frame_aborted
  );
  logic [4:0] nfall;
  // serial falls since select rose
  always_ff @(negedge shift_conv_clock or negedge conv_select_n)
    if (!conv_select_n)
      nfall <= 5'h00;
    else if (nfall != 5'h1F)
      nfall <= nfall + 5'h01;

  chk_rise_drive: assert property (@(posedge core_clk) disable iff (!reset_n)
    $rose(conv_select_n) |-> !serial_result_oe_n && !serial_result_out && !track_hold)
    else $error("select rise did not drive a zero in hold");
  chk_fall_float: assert property (@(posedge core_clk) disable iff (!reset_n)
    $fell(conv_select_n) |-> serial_result_oe_n && track_hold)
    else $error("select fall did not float and track");
  chk_wake_up: assert property (@(posedge core_clk) disable iff (!reset_n)
    $fell(conv_select_n) |-> ##[1:8] powered_up)
    else $error("no power up after select fall");
  chk_edge_only: assert property (@(posedge core_clk) disable iff (!reset_n)
    $changed(serial_result_out) && !serial_result_oe_n && $stable(serial_result_oe_n)
    |-> $fell(shift_conv_clock))
    else $error("data changed off a falling serial edge");
  chk_oe_window: assert property (@(posedge shift_conv_clock) disable iff (!reset_n)
    conv_select_n |-> serial_result_oe_n == (nfall >= 5'h10))
    else $error("driver enable wrong for fall count");
  chk_lead_zero: assert property (@(posedge shift_conv_clock) disable iff (!reset_n)
    conv_select_n && nfall < 5'h04 |-> !serial_result_out)
    else $error("leading bit not zero");
  chk_hold_phase: assert property (@(posedge shift_conv_clock) disable iff (!reset_n)
    conv_select_n && nfall <= 5'h0C |-> !track_hold)
    else $error("tracking before the 13th rise");
  chk_track_back: assert property (@(negedge shift_conv_clock) disable iff (!reset_n)
    conv_select_n && nfall >= 5'h0D && nfall <= 5'h0F |-> track_hold)
    else $error("not tracking after the 13th rise");
  chk_done_pulse: assert property (@(posedge core_clk) disable iff (!reset_n)
    $rose(serial_result_oe_n) && conv_select_n |-> ##[1:8] frame_done)
    else $error("no frame done after 16 falls");
  chk_abort_pulse: assert property (@(posedge core_clk) disable iff (!reset_n)
    $fell(conv_select_n) && !$past(serial_result_oe_n) |-> ##[1:8] frame_aborted)
    else $error("no abort report");

  cov_done: cover property (@(posedge core_clk) frame_done);
  cov_abort: cover property (@(posedge core_clk) frame_aborted);
  cov_last: cover property (@(negedge shift_conv_clock) nfall == 5'h0F);
endmodule // sarro_readout_props

bind sarro_readout sarro_readout_props i_props
  (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .shift_conv_clock(shift_conv_clock),
    .conv_select_n(conv_select_n),
    .serial_result_out(serial_result_out),
    .serial_result_oe_n(serial_result_oe_n),
    .track_hold(track_hold),
    .powered_up(powered_up),
    .frame_done(frame_done),
    .frame_aborted(frame_aborted)
  );
`default_nettype wire

// ### sarro_readout_tb.sv
/*
 testbench for the converter readout block.
 assumes the host model drives the link pins.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) \
  begin \
    n_checks++; \
    if ((a) !== (e)) \
    begin \
      fail_count++; \
      $display("wrong value at %0t: got %h expected %h", $time, (a), (e)); \
    end \
  end
module sarro_readout_tb;
  import sarro_pkg::*;
  logic           core_clk = 1'b0;
  logic           reset_n = 1'b0;
  logic           code_valid = 1'b0;
  sarro_code_type code_in = '0;
  logic           shift_conv_clock, conv_select_n, serial_result_out, serial_result_oe_n;
  logic           track_hold, powered_up, acq_done, code_ready, frame_done, frame_aborted;
  int             fail_count = 0;
  int             n_checks = 0;
  int             cycles = 0;
  int             n_done = 0;
  int             n_abort = 0;
  int             n_acq = 0;
  logic [15:0]    word;
  sarro_code_type codes [8] = '{12'h000, 12'hFFF, 12'hA5C, 12'h5A3,
                                12'h800, 12'h001, 12'h7FE, 12'h123};

  sarro_readout #(.FIFO_DEPTH(8)) i_dut
    (.core_clk(core_clk), .reset_n(reset_n), .shift_conv_clock(shift_conv_clock),
     .conv_select_n(conv_select_n), .serial_result_out(serial_result_out),
     .serial_result_oe_n(serial_result_oe_n), .track_hold(track_hold),
     .powered_up(powered_up), .acq_done(acq_done), .code_valid(code_valid),
     .code_ready(code_ready), .code_in(code_in), .frame_done(frame_done),
     .frame_aborted(frame_aborted));
  sarro_host i_host
    (.shift_conv_clock(shift_conv_clock), .conv_select_n(conv_select_n),
     .serial_result_out(serial_result_out), .serial_result_oe_n(serial_result_oe_n));

  always #2 core_clk = ~core_clk;
  always @(posedge core_clk)
  begin
    cycles++;
    n_done += (frame_done === 1'b1);
    n_abort += (frame_aborted === 1'b1);
    n_acq += (acq_done === 1'b1);
    if (cycles == 10000)
    begin
      fail_count++;
      test_done();
    end
  end

  task automatic test_done();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // push all codes, then the buffer must refuse
  task automatic fill_fifo();
    for (int i = 0; i < 8; i++)
    begin
      code_valid <= 1'b1;
      code_in <= codes[i];
      do @(posedge core_clk); while (code_ready !== 1'b1);
    end
    code_valid <= 1'b0;
    @(posedge core_clk);
    #1;
    `CHK(code_ready, 1'b0)
  endtask

  // complete frame and its report
  task automatic full_frame(input sarro_code_type exp);
    int done0;
    int acq0;
    done0 = n_done;
    acq0 = n_acq;
    i_host.frame(16, word);
    `CHK(word, {4'h0, exp})
    `CHK(n_acq != acq0, 1'b1)
    repeat (12) @(posedge core_clk);
    `CHK(serial_result_oe_n, 1'b1)
    `CHK(powered_up, 1'b0)
    `CHK(n_done, done0 + 1)
    `CHK(code_ready, 1'b1)
  endtask

  // abort after nine falls, then an ordinary frame of the same code
  task automatic abort_frame(input sarro_code_type exp);
    int ab0;
    ab0 = n_abort;
    i_host.frame(9, word);
    #1;
    `CHK(word[15:6], {4'h0, exp[11:6]})
    `CHK(serial_result_oe_n, 1'b1)
    `CHK(track_hold, 1'b1)
    repeat (12) @(posedge core_clk);
    `CHK(n_abort, ab0 + 1)
    full_frame(exp);
  endtask

  initial
  begin
    repeat (6) @(posedge core_clk);
    reset_n <= 1'b1;
    @(posedge core_clk);
    `CHK(serial_result_oe_n, 1'b1)
    fill_fifo();
    full_frame(codes[0]);
    abort_frame(codes[1]);
    for (int i = 2; i < 8; i++)
      full_frame(codes[i]);
    test_done();
  end
endmodule // sarro_readout_tb
`default_nettype wire
